// >>> include/perf_counter_pkg.sv
// Purpose: shared constants and carriers for the event counter pairs
// Assumes: byte addresses inside one configuration-space function
// Notes: all reset values of the block are zero

package perf_counter_pkg;

  // counter geometry
  localparam int NUM_CTR = 3;
  localparam int CNT_W = 44;
  localparam int CNT_HI_W = CNT_W - 32;
  localparam int NUM_EVENTS = 64;
  localparam int EVT_IDX_W = 6;

  // register byte offsets in configuration space
  localparam logic [11:0] OFS_BOX_STATUS = 12'h0f8;
  localparam logic [11:0] OFS_BOX_CTL = 12'h0f4;
  localparam logic [11:0] OFS_CTL0 = 12'h0d8;
  localparam logic [11:0] CTL_STRIDE = 12'h004;
  localparam logic [11:0] OFS_CNT0_LO = 12'h0a0;
  localparam logic [11:0] CNT_STRIDE = 12'h008;
  localparam logic [11:0] CNT_HI_OFS = 12'h004;

  // box-wide control field positions
  localparam int BOX_HALT_BIT = 8;
  localparam int BOX_RST_CNT_BIT = 1;
  localparam int BOX_RST_CTL_BIT = 0;

  // control field positions used by the decoder
  localparam int CTL_CLEAR_BIT = 17;

  // bits of a control write that are kept (reserved bits 23, 21, 19, 16 and clear dropped)
  localparam logic [31:0] CTL_STORE_MASK = 32'hff54ffff;

  // reset values
  localparam logic [31:0] CTL_RESET = 32'h00000000;
  localparam logic [CNT_W-1:0] CNT_RESET = 44'h00000000000;
  localparam logic [NUM_CTR-1:0] FLAGS_RESET = 3'h0;

  // counter control register layout
  typedef struct packed {
    logic [7:0] threshold;
    logic rsv23;
    logic enable;
    logic rsv21;
    logic wrap_report_enable;
    logic ign19;
    logic edge_mode;
    logic clear;
    logic rsv16;
    logic [7:0] subevent_mask;
    logic [7:0] event_selector;
  } ctl_t;

  // one event source: per-cycle quantity and subevent hits
  typedef struct packed {
    logic [7:0] quantity;
    logic [7:0] subevents;
  } event_lane_t;

  // configuration access request
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } cfg_req_t;

  // configuration access answer
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } cfg_rsp_t;

endpackage

// >>> verilog/event_counter_slice.sv
// Purpose: one 44-bit event counter with threshold and edge shaping
// Assumes: event quantity comes from logic on the same clock
// Notes: clear beats a write, a write beats counting

`timescale 1ns/10ps
`default_nettype none

module event_counter_slice
  import perf_counter_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire ctl_t ctl_i,
  input wire logic [7:0] quantity_i,
  input wire logic halt_i,
  input wire logic clear_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [31:0] wdata_i,
  output logic [CNT_W-1:0] count_o,
  output logic wrap_o
);

  // all state of the slice
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic prev_active;
    logic wrap;
  } slice_state_t;

  slice_state_t s_q;
  slice_state_t s_d;
  logic active; // thresholded event seen
  logic [7:0] inc; // amount added this cycle
  logic run; // counting allowed
  logic [CNT_W:0] sum; // count plus increment with carry

  // shaping, increment and load priority
  always_comb begin
    if (ctl_i.threshold == 8'h00) begin
      active = (quantity_i != 8'h00);
    end else begin
      active = (quantity_i >= ctl_i.threshold);
    end
    if (ctl_i.edge_mode) begin
      inc = {7'h00, active & ~s_q.prev_active};
    end else if (ctl_i.threshold == 8'h00) begin
      inc = quantity_i;
    end else begin
      inc = {7'h00, active};
    end
    run = ctl_i.enable & ~halt_i;
    sum = {1'b0, s_q.count} + {{(CNT_W - 7){1'b0}}, inc};
    s_d = s_q;
    s_d.wrap = 1'b0;
    s_d.prev_active = active;
    if (clear_i) begin
      s_d.count = CNT_RESET;
    end else if (wr_lo_i) begin
      s_d.count[31:0] = wdata_i;
    end else if (wr_hi_i) begin
      s_d.count[CNT_W-1:32] = wdata_i[CNT_HI_W-1:0];
    end else if (run) begin
      s_d.count = sum[CNT_W-1:0];
      s_d.wrap = sum[CNT_W] & ctl_i.wrap_report_enable;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.count;
  assign wrap_o = s_q.wrap;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // a cycle of plain counting, nothing loaded
  sequence steady_run;
    run && !clear_i && !wr_lo_i && !wr_hi_i;
  endsequence

  // a cycle with no counting and nothing loaded
  sequence idle_hold;
    !run && !clear_i && !wr_lo_i && !wr_hi_i;
  endsequence

  chk_hold_disabled: assert property (idle_hold |=> $stable(count_o))
    else $error("counter moved while disabled");

  chk_level_adds: assert property (
    (steady_run and (!ctl_i.edge_mode && ctl_i.threshold == 8'h00))
    |=> count_o == CNT_W'($past(s_q.count) + CNT_W'($past(quantity_i))))
    else $error("level mode did not add the quantity");

  chk_edge_held: assert property (
    (steady_run and (ctl_i.edge_mode && active && s_q.prev_active))
    |=> $stable(count_o))
    else $error("edge mode counted a held level");

  chk_clear_zero: assert property (clear_i |=> count_o == CNT_RESET)
    else $error("clear did not zero the counter");

  chk_wrap_detect: assert property (
    (steady_run and (sum[CNT_W] && ctl_i.wrap_report_enable))
    |=> wrap_o && count_o == $past(sum[CNT_W-1:0]))
    else $error("carry out not reported or count not wrapped");

endmodule

`default_nettype wire

// >>> verilog/perf_event_counter_pair.sv
// Purpose: three counter/control pairs with box status and halt
// Assumes: event lanes and config port run on clk_i
// Notes: answers one cycle after each config access

`timescale 1ns/10ps
`default_nettype none

// What this block does
// - event selector picks the counted source
// - subevent mask picks contributing subevents
// - threshold byte held for quantity compare
// - level mode counts every asserted cycle
// - edge mode counts only rising transitions
// - reported wrap sets flag, sends message
// - global unit sets this agent's bit
// - clear bit zeroes counter, not kept
// - count is low 44 bits only
// - wrap is carry out of bit 43
// - counter wraps and keeps counting
// - count preloadable to freeze after N
// - counts readable while counting continues
// - status flags clear on writing one
// - box halt bit freezes all counters
// - up to eight bits added per cycle
module perf_event_counter_pair
  import perf_counter_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire cfg_req_t cfg_i,
  input wire event_lane_t [NUM_EVENTS-1:0] event_lanes_i,
  input wire logic global_freeze_i,
  output cfg_rsp_t cfg_o,
  output logic link_wrap_request_o,
  output logic [NUM_CTR-1:0] wrap_flags_o
);

  // all state of the block
  typedef struct packed {
    ctl_t [NUM_CTR-1:0] ctl;
    logic halt;
    logic [NUM_CTR-1:0] flags;
    logic [31:0] rdata;
    logic ack;
    logic msg;
  } main_state_t;

  main_state_t s_q;
  main_state_t s_d;

  // per counter wires
  logic [NUM_CTR-1:0][CNT_W-1:0] counts; // live counts
  logic [NUM_CTR-1:0] wraps; // reported carry pulses
  logic [NUM_CTR-1:0] clear; // counter clear strobes
  logic [NUM_CTR-1:0] wr_lo; // low word loads
  logic [NUM_CTR-1:0] wr_hi; // high word loads
  logic halt_all; // freeze seen by every slice
  logic cfg_wr; // write access this cycle
  logic cfg_rd; // read access this cycle

  assign cfg_wr = cfg_i.valid & cfg_i.write;
  assign cfg_rd = cfg_i.valid & ~cfg_i.write;

  // local halt or global freeze stops all counting
  assign halt_all = s_q.halt | global_freeze_i;

  // counter strobes decoded from the config write
  always_comb begin
    clear = '0;
    wr_lo = '0;
    wr_hi = '0;
    for (int i = 0; i < NUM_CTR; i++) begin
      if (!cfg_wr) begin
        // nothing written this cycle
        clear[i] = 1'b0;
      end else if (cfg_i.addr == OFS_CTL0 + 12'(i) * CTL_STRIDE) begin
        // clear bit acts once and is dropped
        clear[i] = cfg_i.wdata[CTL_CLEAR_BIT];
      end else if (cfg_i.addr == OFS_CNT0_LO + 12'(i) * CNT_STRIDE) begin
        // low word of the count
        wr_lo[i] = 1'b1;
      end else if (cfg_i.addr ==
                   OFS_CNT0_LO + 12'(i) * CNT_STRIDE + CNT_HI_OFS) begin
        // high word, upper bits ignored in the slice
        wr_hi[i] = 1'b1;
      end else if (cfg_i.addr == OFS_BOX_CTL) begin
        // box-wide counter reset
        clear[i] = cfg_i.wdata[BOX_RST_CNT_BIT];
      end
    end
  end

  // one counter slice per pair
  for (genvar g = 0; g < NUM_CTR; g++) begin : g_ctr
    event_lane_t picked; // lane chosen by the selector
    logic [7:0] qual_qty; // quantity after subevent gating

    // event and subevent selection
    always_comb begin
      if (s_q.ctl[g].event_selector[7:EVT_IDX_W] != '0) begin
        // codes past the last source count nothing
        picked = '0;
      end else begin
        picked = event_lanes_i[s_q.ctl[g].event_selector[EVT_IDX_W-1:0]];
      end
      if (s_q.ctl[g].subevent_mask == 8'h00) begin
        // no mask: whole event counts
        qual_qty = picked.quantity;
      end else if ((picked.subevents & s_q.ctl[g].subevent_mask)
                   != 8'h00) begin
        // a masked subevent fired
        qual_qty = picked.quantity;
      end else begin
        // unselected subevents only
        qual_qty = 8'h00;
      end
    end

    event_counter_slice u_slice (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ctl_i(s_q.ctl[g]),
      .quantity_i(qual_qty),
      .halt_i(halt_all),
      .clear_i(clear[g]),
      .wr_lo_i(wr_lo[g]),
      .wr_hi_i(wr_hi[g]),
      .wdata_i(cfg_i.wdata),
      .count_o(counts[g]),
      .wrap_o(wraps[g])
    );
  end

  // register writes, status flags and read answer
  always_comb begin
    s_d = s_q;
    s_d.ack = cfg_i.valid;
    s_d.rdata = 32'h00000000;
    // one message for any reported wrap
    s_d.msg = |wraps;

    if (cfg_wr) begin
      if (cfg_i.addr == OFS_BOX_STATUS) begin
        // write one to clear each flag
        s_d.flags = s_q.flags & ~cfg_i.wdata[NUM_CTR-1:0];
      end else if (cfg_i.addr == OFS_BOX_CTL) begin
        // halt level and control reset
        s_d.halt = cfg_i.wdata[BOX_HALT_BIT];
        if (cfg_i.wdata[BOX_RST_CTL_BIT]) begin
          s_d.ctl = '0;
        end
      end else begin
        // per-counter control writes
        for (int i = 0; i < NUM_CTR; i++) begin
          if (cfg_i.addr == OFS_CTL0 + 12'(i) * CTL_STRIDE) begin
            // reserved bits 23, 21, 19, 16 and the clear bit never stored
            s_d.ctl[i] = ctl_t'(cfg_i.wdata & CTL_STORE_MASK);
          end
        end
      end
    end

    // a new wrap wins over a clear in the same cycle
    s_d.flags = s_d.flags | wraps;

    if (cfg_rd) begin
      if (cfg_i.addr == OFS_BOX_STATUS) begin
        // sticky wrap flags, upper bits zero
        s_d.rdata = {{(32 - NUM_CTR){1'b0}}, s_q.flags};
      end else if (cfg_i.addr == OFS_BOX_CTL) begin
        // box control is write-only
        s_d.rdata = 32'h00000000;
      end else begin
        for (int i = 0; i < NUM_CTR; i++) begin
          if (cfg_i.addr == OFS_CTL0 + 12'(i) * CTL_STRIDE) begin
            // stored control fields
            s_d.rdata = 32'(s_q.ctl[i]);
          end else if (cfg_i.addr == OFS_CNT0_LO + 12'(i) * CNT_STRIDE) begin
            // low count word, read while counting
            s_d.rdata = counts[i][31:0];
          end else if (cfg_i.addr ==
                       OFS_CNT0_LO + 12'(i) * CNT_STRIDE + CNT_HI_OFS) begin
            // high count word, ignored bits zero
            s_d.rdata = {{(64 - CNT_W){1'b0}}, counts[i][CNT_W-1:32]};
          end
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign cfg_o.ack = s_q.ack;
  assign cfg_o.rdata = s_q.rdata;
  assign link_wrap_request_o = s_q.msg;
  assign wrap_flags_o = s_q.flags;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_status_sticky: assert property (
    (|wraps) |=> ((wrap_flags_o & $past(wraps)) == $past(wraps)))
    else $error("wrap flag not set");

  chk_message_sent: assert property ((|wraps) |=> link_wrap_request_o)
    else $error("wrap message missing");

  chk_halt_freezes: assert property (
    (s_q.halt && !cfg_i.valid) |=> $stable(counts))
    else $error("counts moved while halted");

  chk_access_ack: assert property (
    cfg_rd |=> cfg_o.ack ##1 !cfg_o.ack || $past(cfg_i.valid))
    else $error("read not answered");

endmodule

`default_nettype wire

// >>> test/global_unit_model.sv
// Purpose: model of the global monitoring unit taking wrap messages
// Assumes: the wrap message is a one-cycle pulse on clk_i
// Notes: when armed, a message freezes all counting until cleared

`timescale 1ns/10ps
`default_nettype none

module global_unit_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wrap_request_i,
  input wire logic arm_i,
  input wire logic clear_i,
  output logic status_o,
  output logic freeze_o
);
  // sticky status bit for this agent, freeze set on the same edge when armed
  always_ff @(posedge clk_i) begin
    if (reset_i || clear_i) begin
      status_o <= 1'b0;
      freeze_o <= 1'b0;
    end else if (wrap_request_i) begin
      status_o <= 1'b1;
      freeze_o <= arm_i;
    end
  end
endmodule

`default_nettype wire

// >>> test/tb_perf_event_counter_pair.sv
// Purpose: self-checking bench for the three counter/control pairs
// Assumes: config answers come one cycle after the request edge
// Notes: event lane 9 stays busy to catch a wrong event choice

`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  err_total++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end

module tb_perf_event_counter_pair;
  import perf_counter_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  cfg_req_t cfg_i = '0;
  event_lane_t [NUM_EVENTS-1:0] lanes = '0;
  cfg_rsp_t cfg_o;
  logic wrap_req;
  logic freeze;
  logic gstat;
  logic arm = 1'b0;
  logic gclr = 1'b0;
  logic [NUM_CTR-1:0] flags;
  logic [31:0] rd;
  int err_total = 0;
  int compares = 0;

  perf_event_counter_pair u_dut (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .cfg_i(cfg_i),
    .event_lanes_i(lanes),
    .global_freeze_i(freeze),
    .cfg_o(cfg_o),
    .link_wrap_request_o(wrap_req),
    .wrap_flags_o(flags)
  );

  global_unit_model u_global (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wrap_request_i(wrap_req),
    .arm_i(arm),
    .clear_i(gclr),
    .status_o(gstat),
    .freeze_o(freeze)
  );

  // 50 ns clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // one config access, answer sampled once the take edge has landed
  task automatic access(input logic wr, input logic [11:0] a,
                        input logic [31:0] d);
    @(posedge clk_i) cfg_i <= '{1'b1, wr, a, d};
    @(posedge clk_i) cfg_i <= '0;
    #1;
    `CHK("ack", 1'b1, cfg_o.ack)
    rd = cfg_o.rdata;
  endtask

  // read and compare
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex);
    access(1'b0, a, 32'h00000000);
    `CHK("rdata", ex, rd)
  endtask

  // hold one lane for n sampling edges
  task automatic drive(input int ln, input logic [7:0] q,
                       input logic [7:0] s, input int n);
    @(posedge clk_i) lanes[ln] <= '{q, s};
    repeat (n - 1) @(posedge clk_i);
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog, the sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    finish_test();
  end

  initial begin
    lanes[9].quantity <= 8'h07;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    // reset values, unmapped place
    rd_chk(OFS_CTL0, 32'h00000000);
    rd_chk(OFS_CNT0_LO + CNT_HI_OFS, 32'h00000000);
    rd_chk(12'h000, 32'h00000000);
    // control fields kept, clear bit dropped
    access(1'b1, OFS_CTL0, 32'h0356ff05);
    rd_chk(OFS_CTL0, 32'h0354ff05);
    $display("test fields done");
    // level mode adds quantity, full byte included
    access(1'b1, OFS_CTL0, 32'h00400005);
    drive(5, 8'h03, 8'h00, 10);
    drive(5, 8'hff, 8'h00, 2);
    drive(5, 8'h00, 8'h00, 1);
    rd_chk(OFS_CNT0_LO, 32'd540);
    rd_chk(OFS_CNT0_LO + CNT_HI_OFS, 32'h00000000);
    // disabled counter holds
    access(1'b1, OFS_CTL0, 32'h00000005);
    drive(5, 8'h03, 8'h00, 4);
    drive(5, 8'h00, 8'h00, 1);
    rd_chk(OFS_CNT0_LO, 32'd540);
    access(1'b1, OFS_CTL0, 32'h00020005);
    rd_chk(OFS_CNT0_LO, 32'h00000000);
    rd_chk(OFS_CTL0, 32'h00000005);
    $display("test level done");
    // threshold two: only quantities 2 and 3 count
    access(1'b1, OFS_CTL0, 32'h02400005);
    drive(5, 8'h01, 8'h00, 1);
    drive(5, 8'h02, 8'h00, 1);
    drive(5, 8'h03, 8'h00, 1);
    drive(5, 8'h00, 8'h00, 1);
    rd_chk(OFS_CNT0_LO, 32'd2);
    // edge mode with threshold one
    access(1'b1, OFS_CTL0, 32'h01460005);
    drive(5, 8'h01, 8'h00, 3);
    drive(5, 8'h00, 8'h00, 2);
    drive(5, 8'h01, 8'h00, 2);
    drive(5, 8'h00, 8'h00, 1);
    rd_chk(OFS_CNT0_LO, 32'd2);
    // subevent mask
    access(1'b1, OFS_CTL0, 32'h00420205);
    drive(5, 8'h04, 8'h01, 3);
    drive(5, 8'h04, 8'h02, 2);
    drive(5, 8'h00, 8'h00, 1);
    rd_chk(OFS_CNT0_LO, 32'd8);
    $display("test shaping done");
    // preload near wrap, counter 0 reports, counter 1 does not
    @(posedge clk_i) arm <= 1'b1;
    access(1'b1, OFS_CTL0, 32'h00500005);
    access(1'b1, OFS_CTL0 + CTL_STRIDE, 32'h00400005);
    access(1'b1, OFS_CNT0_LO + CNT_HI_OFS, 32'h00000fff);
    access(1'b1, OFS_CNT0_LO, 32'hfffffffd);
    access(1'b1, OFS_CNT0_LO + CNT_STRIDE + CNT_HI_OFS, 32'h00000fff);
    access(1'b1, OFS_CNT0_LO + CNT_STRIDE, 32'hffffffff);
    drive(5, 8'h01, 8'h00, 8);
    drive(5, 8'h00, 8'h00, 1);
    rd_chk(OFS_CNT0_LO, 32'd2);
    rd_chk(OFS_CNT0_LO + CNT_HI_OFS, 32'h00000000);
    rd_chk(OFS_CNT0_LO + CNT_STRIDE, 32'd4);
    `CHK("flags", 3'h1, flags)
    `CHK("global", 1'b1, gstat)
    access(1'b1, OFS_BOX_STATUS, 32'h00000002);
    `CHK("flags", 3'h1, flags)
    access(1'b1, OFS_BOX_STATUS, 32'h00000001);
    `CHK("flags", 3'h0, flags)
    @(posedge clk_i) gclr <= 1'b1;
    @(posedge clk_i) gclr <= 1'b0;
    $display("test wrap done");
    // box halt freezes counting until released
    access(1'b1, OFS_CTL0, 32'h00420005);
    access(1'b1, OFS_BOX_CTL, 32'h00000100);
    drive(5, 8'h02, 8'h00, 3);
    drive(5, 8'h00, 8'h00, 1);
    rd_chk(OFS_CNT0_LO, 32'd0);
    rd_chk(OFS_BOX_CTL, 32'h00000000);
    access(1'b1, OFS_BOX_CTL, 32'h00000000);
    drive(5, 8'h02, 8'h00, 3);
    drive(5, 8'h00, 8'h00, 1);
    rd_chk(OFS_CNT0_LO, 32'd6);
    $display("test halt done");
    finish_test();
  end
endmodule

`default_nettype wire
